/* bench/pcw_cpu_model.sv */
// Purpose: Processor side: state pins and reset pulse record
// Assumes: Bench sets the wanted state between edges
// Notes:   Pins move only after a rising edge, as a core would
`timescale 1ns/10ps
`default_nettype none
module pcw_cpu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Wanted state: vector mode, debug, low power, wait
    input  wire logic [3:0] want,
    // From the watchdog
    input  wire logic       sys_reset_all,
    // Processor state pins
    output var  logic       cpu_wait,
    output var  logic       cpu_low_power,
    output var  logic       cpu_debug,
    output var  logic       ext_vec_mode,
    // Reset pulse record
    output var  logic [7:0] pulses,
    output var  logic [7:0] last_len
);
    logic [7:0] run_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {ext_vec_mode, cpu_debug, cpu_low_power, cpu_wait} <= 4'h0;
            pulses   <= 8'h00;
            last_len <= 8'h00;
            run_reg  <= 8'h00;
        end else begin
            {ext_vec_mode, cpu_debug, cpu_low_power, cpu_wait} <= want;
            run_reg <= sys_reset_all ? run_reg + 8'h01 : 8'h00;
            if (sys_reset_all && run_reg == 8'h00) pulses <= pulses + 8'h01;
            if (!sys_reset_all && run_reg != 8'h00) last_len <= run_reg;
        end
    end
endmodule : pcw_cpu_model
`default_nettype wire

/* bench/pcw_wdog_chk.sv */
// Purpose: Port assertions for the watchdog
// Assumes: Sees only the top ports
// Notes:   Bound below the module
`timescale 1ns/10ps
`default_nettype none
module pcw_wdog_chk #(
    parameter int CNT_W    = 32,
    parameter int RST_HOLD = 16
) (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST,
    // Register port
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    // Processor state
    input wire logic        CPU_WAIT,
    input wire logic        CPU_LOW_POWER,
    input wire logic        CPU_DEBUG,
    input wire logic        EXT_VEC_MODE,
    // Outputs
    input wire logic [5:0]  IRQ_LINES,
    input wire logic        IRQ_VEC_REQ,
    input wire logic        NMI_REQ,
    input wire logic        SYS_RESET_ALL
);
    logic [7:0] hold_cnt_reg;
    // Too long for a repetition, so counted
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) hold_cnt_reg <= 8'h00;
        else hold_cnt_reg <= SYS_RESET_ALL ? hold_cnt_reg + 8'h01 : 8'h00;
    end
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_on_wr;
        REG_WR && REG_ADDR == 8'h90 && REG_WDATA[0];
    endsequence
    sequence s_mask_off;
        REG_WR && REG_ADDR == 8'h0C && REG_WDATA[0];
    endsequence
    sequence s_quiet;
        IRQ_LINES == 6'h00 && !IRQ_VEC_REQ && !NMI_REQ;
    endsequence
    chk_on_clears: assert property (s_on_wr |-> ##2 s_quiet)
        else $error("Outputs up after enable write");
    chk_mask_gate: assert property (s_mask_off |-> ##2 s_quiet)
        else $error("Interrupt passed a cleared mask");
    chk_rdata_slot: assert property (REG_RDATA != 32'h0000_0000 |-> $past(REG_RD))
        else $error("Read data outside answer cycle");
    chk_wo_read: assert property (
        REG_RD && (REG_ADDR == 8'h0C || REG_ADDR == 8'h10) |=> REG_RDATA == 32'h0000_0000)
        else $error("Write-only register read nonzero");
    chk_line_onehot: assert property (!IRQ_VEC_REQ |-> $onehot0(IRQ_LINES))
        else $error("Several lines driven");
    chk_vec_mode: assert property (IRQ_VEC_REQ |-> $past(EXT_VEC_MODE) && !NMI_REQ)
        else $error("Vector request outside vector mode");
    chk_nmi_alone: assert property (NMI_REQ |-> IRQ_LINES == 6'h00 && !IRQ_VEC_REQ)
        else $error("NMI and line both driven");
    chk_reset_width: assert property (
        $fell(SYS_RESET_ALL) |-> hold_cnt_reg == 8'(RST_HOLD))
        else $error("System reset pulse width wrong");
endmodule : pcw_wdog_chk
bind pcw_wdog pcw_wdog_chk #(.CNT_W(CNT_W), .RST_HOLD(RST_HOLD)) pcw_wdog_chk_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_WAIT(CPU_WAIT),
    .CPU_LOW_POWER(CPU_LOW_POWER), .CPU_DEBUG(CPU_DEBUG), .EXT_VEC_MODE(EXT_VEC_MODE),
    .IRQ_LINES(IRQ_LINES), .IRQ_VEC_REQ(IRQ_VEC_REQ), .NMI_REQ(NMI_REQ),
    .SYS_RESET_ALL(SYS_RESET_ALL));
`default_nettype wire

/* bench/test_pcw_wdog.sv */
// Purpose: Self-checking bench for the per-core watchdog
// Assumes: Short reset pulse, 50 MHz clock
// Notes:   One task per scenario
`timescale 1ns/10ps
`default_nettype none
module test_pcw_wdog;
    localparam int HOLD = 2;
    logic        CLK_SYS = 1'b0;
    logic        RST = 1'b0;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0000_0000;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [3:0]  want = 4'h0;
    logic [31:0] REG_RDATA;
    logic [5:0]  IRQ_LINES;
    logic        IRQ_VEC_REQ, NMI_REQ, SYS_RESET_ALL;
    logic        CPU_WAIT, CPU_LOW_POWER, CPU_DEBUG, EXT_VEC_MODE;
    logic [7:0]  pulses, last_len;
    int          n_errors = 0;
    int          total_checks = 0;

    always #10 CLK_SYS = ~CLK_SYS;

    pcw_wdog #(.CNT_W(32), .RST_HOLD(HOLD)) pcw_wdog_i (
        .CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_WAIT(CPU_WAIT),
        .CPU_LOW_POWER(CPU_LOW_POWER), .CPU_DEBUG(CPU_DEBUG), .EXT_VEC_MODE(EXT_VEC_MODE),
        .IRQ_LINES(IRQ_LINES), .IRQ_VEC_REQ(IRQ_VEC_REQ), .NMI_REQ(NMI_REQ),
        .SYS_RESET_ALL(SYS_RESET_ALL));
    pcw_cpu_model pcw_cpu_model_i (
        .clk(CLK_SYS), .rst(RST), .want(want), .sys_reset_all(SYS_RESET_ALL),
        .cpu_wait(CPU_WAIT), .cpu_low_power(CPU_LOW_POWER), .cpu_debug(CPU_DEBUG),
        .ext_vec_mode(EXT_VEC_MODE), .pulses(pulses), .last_len(last_len));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Trailing idle edge keeps a strobe from being set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
        @(posedge CLK_SYS);
    endtask : rd
    task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(w, e, d);
    endtask : rdchk
    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic t_reset_values;
        logic [7:0] a [9] = '{8'h90, 8'h40, 8'h98, 8'h94, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        foreach (a[i]) rdchk("reset", a[i], a[i] == 8'h40 ? 32'h8000_0000 : 32'h0);
        wr(8'h94, 32'h1234_5678);
        rdchk("count wr", 8'h94, 32'h0000_0000);
        wr(8'h98, 32'hA5A5_5A5A);
        rdchk("reload", 8'h98, 32'hA5A5_5A5A);
        // Both select bits written: only the line route may survive
        wr(8'h40, 32'hC000_0003);
        rdchk("route both", 8'h40, 32'h8000_0003);
    endtask : t_reset_values
    task automatic t_suspend;
        logic [5:0] cfg [7] = '{6'h05, 6'h05, 6'h05, 6'h15, 6'h05, 6'h25, 6'h04};
        logic [3:0] st [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h0};
        logic [1:0] dif [7] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
        logic [31:0] d0, d1;
        wr(8'h90, 32'h0000_0000);
        wr(8'h98, 32'h0000_0064);
        foreach (cfg[i]) begin
            want <= st[i];
            wr(8'h90, {26'h0, cfg[i]});
            rd(8'h94, d0);
            rd(8'h94, d1);
            chk("step", {30'h0, dif[i]}, d0 - d1);
            if (cfg[i][0]) chk("loaded", 32'h0000_0064 - dif[i][1], d0);
        end
    endtask : t_suspend
    task automatic t_routes;
        logic ext [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [31:0] rt [5] = '{32'h8000_0002, 32'h8000_0005, 32'h8000_0006,
                                32'h8000_0025, 32'h4000_0000};
        logic [5:0] cfg [5] = '{6'h05, 6'h01, 6'h0F, 6'h05, 6'h05};
        // Expected {nmi, vector, lines}
        logic [7:0] ex [5] = '{8'h04, 8'h20, 8'h00, 8'h65, 8'h80};
        wr(8'h10, 32'h0000_0001);
        rdchk("mask set", 8'h08, 32'h0000_0001);
        foreach (rt[i]) begin
            want <= {ext[i], 3'h0};
            wr(8'h40, rt[i]);
            wr(8'h98, 32'h0000_0002);
            wr(8'h90, {26'h0, cfg[i]});
            repeat (6) @(posedge CLK_SYS);
            #1 chk("outs", {24'h0, ex[i]}, {24'h0, NMI_REQ, IRQ_VEC_REQ, IRQ_LINES});
            rdchk("pending", 8'h04, 32'h0000_0001);
            rdchk("halted", 8'h94, 32'h0000_0000);
        end
        wr(8'h0C, 32'h0000_0001);
        @(posedge CLK_SYS);
        #1 chk("masked nmi", 32'h0, {31'h0, NMI_REQ});
        rdchk("mask clr", 8'h08, 32'h0000_0000);
        want <= 4'h0;
    endtask : t_routes
    task automatic t_interval;
        logic [31:0] d;
        wr(8'h10, 32'h0000_0001);
        wr(8'h40, 32'h8000_0001);
        wr(8'h98, 32'h0000_0004);
        wr(8'h90, 32'h0000_0007);
        for (int i = 0; i < 4; i++) begin
            rd(8'h94, d);
            chk("interval", i[0] ? 32'h0000_0001 : 32'h0000_0003, d);
        end
        #1 chk("line", 32'h0000_0002, {26'h0, IRQ_LINES});
        chk("no reset", 32'h0, {24'h0, pulses});
    endtask : t_interval
    task automatic t_second;
        wr(8'h0C, 32'h0000_0001);
        wr(8'h98, 32'h0000_0006);
        // Reload by software before each second expiry
        repeat (4) begin
            wr(8'h90, 32'h0000_0003);
            repeat (7) @(posedge CLK_SYS);
        end
        chk("rescued", 32'h0, {24'h0, pulses});
        wr(8'h98, 32'h0000_0003);
        wr(8'h90, 32'h0000_0003);
        repeat (20) @(posedge CLK_SYS);
        chk("pulses", 32'h0000_0001, {24'h0, pulses});
        chk("width", HOLD, {24'h0, last_len});
        chk("masked", 32'h0, {26'h0, IRQ_LINES});
    endtask : t_second

    initial begin
        #(20 * 5000);
        n_errors++;
        final_report;
    end
    initial begin
        RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        t_reset_values;
        t_suspend;
        t_routes;
        t_interval;
        t_second;
        final_report;
    end
endmodule : test_pcw_wdog
`default_nettype wire

/* logic/pcw_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog
// Assumes: 8-bit register byte address, 32-bit register data
// Notes:   Definitions only
`ifndef PCW_CFG_SVH
`define PCW_CFG_SVH

// Register byte offsets
`define PCW_OFS_PEND      8'h04
`define PCW_OFS_MASK      8'h08
`define PCW_OFS_MASK_CLR  8'h0C
`define PCW_OFS_MASK_SET  8'h10
`define PCW_OFS_ROUTE     8'h40
`define PCW_OFS_CONFIG    8'h90
`define PCW_OFS_COUNT     8'h94
`define PCW_OFS_RELOAD    8'h98

// Configuration register fields
`define PCW_CFG_ON_BIT    0
`define PCW_CFG_ACT_LSB   1
`define PCW_CFG_ACT_MSB   3
`define PCW_CFG_LP_BIT    4
`define PCW_CFG_DBG_BIT   5

// Route register fields
`define PCW_RT_LINE_BIT   31
`define PCW_RT_NMI_BIT    30
`define PCW_RT_MAP_MSB    5

// Local pending and mask bit of the watchdog source
`define PCW_SRC_BIT       0

// Expiry actions
`define PCW_ACT_SECOND    3'h1
`define PCW_ACT_ONE_TRIP  3'h2
`define PCW_ACT_INTERVAL  3'h3

// Reset values
`define PCW_CFG_RESET     6'h00
`define PCW_ROUTE_LINE_RST 1'b1
`define PCW_ROUTE_MAP_RST 6'h00
`define PCW_RELOAD_RESET  32'h0000_0000
`define PCW_MASK_RESET    1'b0

// Number of processor interrupt lines
`define PCW_IRQ_LINES     6

// System reset pulse width
`define PCW_CLK_PERIOD_NS 20
`define PCW_RST_HOLD_NS   320
`define PCW_RST_HOLD_CYC  ((`PCW_RST_HOLD_NS + `PCW_CLK_PERIOD_NS - 1) / `PCW_CLK_PERIOD_NS)

`endif

/* logic/pcw_countdown.sv */
// Purpose: Loadable down counter with expiry detect
// Assumes: Load and decrement may come in the same cycle, load wins
// Notes:   Expiry fires on the step that lands on zero, or on a step at zero
`timescale 1ns/10ps
`default_nettype none
module pcw_countdown #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    // State
    output var  logic [W-1:0] count,
    output var  logic         expire
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    wire          at_one  = (count_reg == W'(1));
    wire          at_zero = (count_reg == '0);

    assign expire     = dec && (at_one || at_zero);
    assign count_next = load ? load_val :
                        (dec && !at_zero) ? count_reg - W'(1) : count_reg;
    assign count      = count_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : pcw_countdown
`default_nettype wire

/* logic/pcw_pkg.sv */
// Purpose: Types shared by the watchdog files
// Assumes: Nothing beyond the config header
// Notes:   Field widths follow the register layout
`default_nettype none
package pcw_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcw_bus_s;

    typedef struct packed {
        logic       dbg_cont;
        logic       lp_cont;
        logic [2:0] action;
        logic       on;
    } pcw_cfg_s;

    typedef struct packed {
        logic       to_line;
        logic       to_nmi;
        logic [5:0] map;
    } pcw_route_s;

    typedef enum logic [1:0] {
        PCW_OFF,
        PCW_RUN,
        PCW_ARMED,
        PCW_HALT
    } pcw_state_e;

endpackage : pcw_pkg
`default_nettype wire

/* logic/pcw_wdog.sv */
// Purpose: Per-processor watchdog with local pending, mask and routing
// Assumes: Register strobes one cycle long, never both at once
// Notes:   Read data stands only in the cycle after the read strobe
//
// What this block does
// - Low-power continue clear: pause counting during wait or low-power state.
// - Debug continue clear: pause counting in debug mode; set means no effect.
// - Action field in config bits 3:1; code 0x2 interrupts and halts.
// - Code 0x1: first expiry interrupts and reloads; second resets all processors.
// - Code 0x3: interrupt, reload and keep counting at every zero.
// - Count only while the timer_on bit is set; clearing it disables.
// - Each write of one to timer_on copies reload value into current count.
// - Current count at 0x0094 is read-only, live; reload value at 0x0098.
// - Watchdog interrupt sets bit 0 of the local pending register at 0x0004.
// - Pending interrupt forwarded only when mask bit 0 at 0x0008 is set.
// - One to bit 0 at 0x0010 sets mask; at 0x000C clears it.
// - Second-expiry system reset ignores the mask bit.
// - Line mode: map bits 5:0 at 0x0040 pick one of six lines.
// - Vector mode: six-bit map driven unchanged on the six lines.
// - Route register holds line and NMI select bits; only one set.
// - Current count is a 32-bit down counter.
// - Route bits 31 and 30 plus bits 5:0 form the software routing control.
`timescale 1ns/10ps
`default_nettype none
`include "pcw_cfg.svh"
module pcw_wdog #(
    parameter int CNT_W    = 32,
    parameter int RST_HOLD = `PCW_RST_HOLD_CYC
) (
    // Clock and reset
    input  wire logic                      CLK_SYS,
    input  wire logic                      RST,
    // Register port
    input  wire logic [7:0]                REG_ADDR,
    input  wire logic [31:0]               REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    output var  logic [31:0]               REG_RDATA,
    // Processor state
    input  wire logic                      CPU_WAIT,
    input  wire logic                      CPU_LOW_POWER,
    input  wire logic                      CPU_DEBUG,
    input  wire logic                      EXT_VEC_MODE,
    // Interrupt and reset outputs
    output var  logic [`PCW_IRQ_LINES-1:0] IRQ_LINES,
    output var  logic                      IRQ_VEC_REQ,
    output var  logic                      NMI_REQ,
    output var  logic                      SYS_RESET_ALL
);

    // Bus decode
    pcw_pkg::pcw_bus_s bus;

    assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

    wire hit_mask_clr = (bus.addr == `PCW_OFS_MASK_CLR);
    wire hit_mask_set = (bus.addr == `PCW_OFS_MASK_SET);
    wire hit_route    = (bus.addr == `PCW_OFS_ROUTE);
    wire hit_config   = (bus.addr == `PCW_OFS_CONFIG);
    wire hit_reload   = (bus.addr == `PCW_OFS_RELOAD);

    wire wr_config    = bus.wr && hit_config;
    wire wr_route     = bus.wr && hit_route;
    wire wr_reload    = bus.wr && hit_reload;
    wire wr_mask_set  = bus.wr && hit_mask_set && bus.wdata[`PCW_SRC_BIT];
    wire wr_mask_clr  = bus.wr && hit_mask_clr && bus.wdata[`PCW_SRC_BIT];

    // Writing one to timer_on, even when already set, re-arms the count
    wire on_write     = wr_config && bus.wdata[`PCW_CFG_ON_BIT];
    wire off_write    = wr_config && !bus.wdata[`PCW_CFG_ON_BIT];

    // Registers
    pcw_pkg::pcw_cfg_s   cfg_reg;
    pcw_pkg::pcw_cfg_s   cfg_next;
    pcw_pkg::pcw_route_s route_reg;
    pcw_pkg::pcw_route_s route_next;
    pcw_pkg::pcw_state_e state_reg;
    pcw_pkg::pcw_state_e state_next;
    logic [CNT_W-1:0]    reload_reg;
    logic [CNT_W-1:0]    reload_next;
    logic                pend_reg;
    logic                pend_next;
    logic                mask_reg;
    logic                mask_next;
    logic [7:0]          rst_cnt_reg;
    logic [7:0]          rst_cnt_next;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic [`PCW_IRQ_LINES-1:0] lines_reg;
    logic [`PCW_IRQ_LINES-1:0] lines_next;
    logic                vec_reg;
    logic                vec_next;
    logic                nmi_reg;
    logic                nmi_next;
    logic                sysrst_reg;
    logic                sysrst_next;

    // Config write
    assign cfg_next = wr_config ? '{
        dbg_cont: bus.wdata[`PCW_CFG_DBG_BIT],
        lp_cont:  bus.wdata[`PCW_CFG_LP_BIT],
        action:   bus.wdata[`PCW_CFG_ACT_MSB:`PCW_CFG_ACT_LSB],
        on:       bus.wdata[`PCW_CFG_ON_BIT]
    } : cfg_reg;

    // A write with both select bits set keeps only the line route
    wire route_line_w = bus.wdata[`PCW_RT_LINE_BIT];
    wire route_nmi_w  = bus.wdata[`PCW_RT_NMI_BIT] && !route_line_w;

    assign route_next = wr_route ? '{
        to_line: route_line_w,
        to_nmi:  route_nmi_w,
        map:     bus.wdata[`PCW_RT_MAP_MSB:0]
    } : route_reg;

    assign reload_next = wr_reload ? bus.wdata[CNT_W-1:0] : reload_reg;

    // Countdown control
    wire suspend_lp  = !cfg_reg.lp_cont && (CPU_WAIT || CPU_LOW_POWER);
    wire suspend_dbg = !cfg_reg.dbg_cont && CPU_DEBUG;
    wire active      = cfg_reg.on &&
                       (state_reg == pcw_pkg::PCW_RUN || state_reg == pcw_pkg::PCW_ARMED);
    // A config write in flight blocks the step so enable changes act cleanly
    wire step        = active && !wr_config && !suspend_lp && !suspend_dbg;

    logic [CNT_W-1:0] count_val;
    logic             expire;

    // Action decode, unknown codes fall back to one-trip
    wire act_second   = (cfg_reg.action == `PCW_ACT_SECOND);
    wire act_interval = (cfg_reg.action == `PCW_ACT_INTERVAL);
    wire act_halt     = !act_second && !act_interval;

    wire first_expiry  = expire && state_reg == pcw_pkg::PCW_RUN;
    wire second_expiry = expire && state_reg == pcw_pkg::PCW_ARMED;
    wire reload_on_exp = first_expiry && (act_second || act_interval);
    wire cnt_load      = on_write || reload_on_exp;

    pcw_countdown #(
        .W        (CNT_W)
    ) u_count (
        .clk      (CLK_SYS),
        .rst      (RST),
        .load     (cnt_load),
        .load_val (reload_reg),
        .dec      (step),
        .count    (count_val),
        .expire   (expire)
    );

    // Timer sequence
    always_comb begin
        state_next = state_reg;
        if (on_write) begin
            state_next = pcw_pkg::PCW_RUN;
        end else if (off_write) begin
            state_next = pcw_pkg::PCW_OFF;
        end else begin
            unique case (state_reg)
                pcw_pkg::PCW_OFF: begin
                    state_next = pcw_pkg::PCW_OFF;
                end
                pcw_pkg::PCW_RUN: begin
                    if (expire) begin
                        if (act_second) begin
                            state_next = pcw_pkg::PCW_ARMED;
                        end else if (act_interval) begin
                            state_next = pcw_pkg::PCW_RUN;
                        end else begin
                            state_next = pcw_pkg::PCW_HALT;
                        end
                    end
                end
                pcw_pkg::PCW_ARMED: begin
                    if (expire) begin
                        state_next = pcw_pkg::PCW_HALT;
                    end
                end
                pcw_pkg::PCW_HALT: begin
                    state_next = pcw_pkg::PCW_HALT;
                end
            endcase
        end
    end

    // Pending and mask, a new expiry beats a simultaneous clear
    wire irq_event = first_expiry;
    assign pend_next = irq_event || (pend_reg && !on_write);
    assign mask_next = wr_mask_set ? 1'b1 :
                       wr_mask_clr ? 1'b0 : mask_reg;

    wire irq_live = pend_reg && mask_reg;

    // Routing
    wire map_ok = (route_reg.map < 6'(`PCW_IRQ_LINES));
    wire [`PCW_IRQ_LINES-1:0] line_onehot =
        map_ok ? (`PCW_IRQ_LINES'(1) << route_reg.map[2:0]) : '0;
    wire to_lines = irq_live && route_reg.to_line;

    assign lines_next = !to_lines     ? '0 :
                        EXT_VEC_MODE  ? route_reg.map : line_onehot;
    assign vec_next   = to_lines && EXT_VEC_MODE;
    assign nmi_next   = irq_live && route_reg.to_nmi;

    // System reset stretch, never gated by the mask
    assign rst_cnt_next = second_expiry ? 8'(RST_HOLD) :
                          (rst_cnt_reg != 8'h00) ? rst_cnt_reg - 8'h01 : rst_cnt_reg;
    assign sysrst_next  = (rst_cnt_next != 8'h00);

    // Read mux, write-only and unmapped offsets read zero
    wire [31:0] rd_pend   = {31'h0000_0000, pend_reg};
    wire [31:0] rd_mask   = {31'h0000_0000, mask_reg};
    wire [31:0] rd_route  = {route_reg.to_line, route_reg.to_nmi, 24'h00_0000, route_reg.map};
    wire [31:0] rd_config = {26'h000_0000, cfg_reg.dbg_cont, cfg_reg.lp_cont,
                             cfg_reg.action, cfg_reg.on};
    wire [31:0] rd_count  = 32'(count_val);
    wire [31:0] rd_reload = 32'(reload_reg);

    wire [31:0] rd_sel =
        (bus.addr == `PCW_OFS_PEND)   ? rd_pend   :
        (bus.addr == `PCW_OFS_MASK)   ? rd_mask   :
        (bus.addr == `PCW_OFS_ROUTE)  ? rd_route  :
        (bus.addr == `PCW_OFS_CONFIG) ? rd_config :
        (bus.addr == `PCW_OFS_COUNT)  ? rd_count  :
        (bus.addr == `PCW_OFS_RELOAD) ? rd_reload : 32'h0000_0000;

    assign rdata_next = bus.rd ? rd_sel : 32'h0000_0000;

    // State registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cfg_reg   <= `PCW_CFG_RESET;
            route_reg <= '{to_line: `PCW_ROUTE_LINE_RST, to_nmi: 1'b0,
                           map: `PCW_ROUTE_MAP_RST};
            reload_reg <= CNT_W'(`PCW_RELOAD_RESET);
            state_reg <= pcw_pkg::PCW_OFF;
            pend_reg  <= 1'b0;
            mask_reg  <= `PCW_MASK_RESET;
            rst_cnt_reg <= 8'h00;
        end else begin
            cfg_reg   <= cfg_next;
            route_reg <= route_next;
            reload_reg <= reload_next;
            state_reg <= state_next;
            pend_reg  <= pend_next;
            mask_reg  <= mask_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    // Output registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata_reg  <= 32'h0000_0000;
            lines_reg  <= '0;
            vec_reg    <= 1'b0;
            nmi_reg    <= 1'b0;
            sysrst_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            lines_reg  <= lines_next;
            vec_reg    <= vec_next;
            nmi_reg    <= nmi_next;
            sysrst_reg <= sysrst_next;
        end
    end

    assign REG_RDATA     = rdata_reg;
    assign IRQ_LINES     = lines_reg;
    assign IRQ_VEC_REQ   = vec_reg;
    assign NMI_REQ       = nmi_reg;
    assign SYS_RESET_ALL = sysrst_reg;

endmodule : pcw_wdog
`default_nettype wire
